// [bia_arb.sv]
`timescale 1ns/1ps
`default_nettype none
module bia_arb (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire bia_pkg::bia_req_t req,
  input wire logic lock,
  input wire logic dmac_hold,
  output bia_pkg::bia_grant_t grant
);
  import bia_pkg::*;

  bia_grant_t next_grant;

  // fixed priority, cpu parks the bus when nobody asks
  function automatic bia_grant_t pick(input bia_req_t r);
    if (r.ext) pick = GR_EXT;
    else if (r.rfsh) pick = GR_RFSH;
    else if (r.data_transfer_ctrl) pick = GR_DTC;
    else if (r.dmac) pick = GR_DMAC;
    else pick = GR_CPU;
  endfunction

  always_comb begin
    next_grant = grant;
    if (!lock) begin
      if (grant == GR_DMAC && dmac_hold && req.dmac && !req.ext && !req.rfsh) begin
        next_grant = GR_DMAC;
      end else begin
        next_grant = pick(req);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      grant <= GR_CPU;
    end else if (clk_en) begin
      grant <= next_grant;
    end
  end
endmodule // bia_arb
`default_nettype wire

// [bia_ext_master.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// far-side master that borrows the bus
// ----------------------------------------------------------------
module bia_ext_master #(
  parameter int DROP_DLY = 2,
  parameter int HOLD_MAX = 400
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic want,
  input wire logic refresh_request_out,
  output logic external_bus_request
);
  int seen;
  int held;
  always_ff @(posedge mclk) begin
    if (sys_rst || !want) begin
      seen <= 0;
      held <= 0;
      external_bus_request <= 1'b0;
    end else begin
      held <= held + 1;
      seen <= seen + int'(refresh_request_out);
      // drops the request a little after refresh is flagged, never holds too long
      external_bus_request <= (seen < DROP_DLY) && (held < HOLD_MAX);
    end
  end
endmodule // bia_ext_master
`default_nettype wire

// [bia_pkg.sv]
package bia_pkg;

  typedef enum logic [2:0] {
    SP_CS0 = 3'h0,
    SP_CS1 = 3'h1,
    SP_CS2 = 3'h2,
    SP_CS3 = 3'h3,
    SP_DRAM = 3'h4
  } bia_space_t;

  typedef struct packed {
    bia_space_t space;
    logic write;
  } bia_access_t;

  typedef struct packed {
    logic [7:0] read_turnaround_idle_fields;
    logic dram_read_turnaround_idle;
    logic [3:0] same_space_idle_fields;
  } bia_idle_cfg_t;

  typedef struct packed {
    logic ext;
    logic rfsh;
    logic data_transfer_ctrl;
    logic dmac;
    logic cpu;
  } bia_req_t;

  typedef enum logic [4:0] {
    GR_CPU = 5'h01,
    GR_DMAC = 5'h02,
    GR_DTC = 5'h04,
    GR_RFSH = 5'h08,
    GR_EXT = 5'h10
  } bia_grant_t;

endpackage

// [bia_regs.svh]
`ifndef BIA_REGS_SVH
`define BIA_REGS_SVH
// Operation
// - A write after a read, or a read of another area after a read, gets the set idle count.
// - Idle cycles already present count toward that figure; only the shortfall is inserted.
// - Each chip-select space 3..0 has its own two-bit idle count used after a read of it.
// - A one-bit dram idle count applies after a dram read followed by a write or cs read.
// - Chip-select idle counts range 0 to 3 cycles, the dram idle count 0 or 1 cycle.
// - Back-to-back accesses to one cs space get one idle, when its bit is set, with the chip select negated.
// - A write after a read of the same cs space gets the larger of the two idle counts.
// - Any idle already between same-space accesses cancels the same-space idle insertion.
// - Bus priority is external request, then refresh, transfer ctrl, dma, and cpu last.
// - A dma in dual-address, burst or indirect transfer keeps the bus against the dtc.
// - When enabled, refresh due while the bus is released raises the refresh request out.
// - The bus is never released inside one bus cycle, however many accesses it holds.
// - An instruction fetch normally takes two instruction words on any bus width.
// - Around a branch the cpu fetches the whole 32-bit pair holding the instruction.

// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define BIA_IW_W 2
`define BIA_CS_SPACES 4

// ----------------------------------------------------------------
// counts and reset values
// ----------------------------------------------------------------
`define BIA_IDLE_SAT 2'h3
`define BIA_IDLE_RST 2'h0
`define BIA_CW_IDLE 2'h1
`define BIA_CS_OFF 4'hF
`define BIA_FETCH_WORDS 2'h2
`define BIA_FETCH_ALIGN 2'h0

`endif

// [bia_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module bia_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic stage1;
      logic stage2;
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end else if (clk_en) begin
          stage1 <= async_in[i];
          stage2 <= stage1;
        end
      end
      assign sync_out[i] = stage2;
    end
  endgenerate
endmodule // bia_sync
`default_nettype wire

// [bia_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bia_regs.svh"
module bia_top (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire bia_pkg::bia_idle_cfg_t idle_cfg,
  input wire logic refresh_out_enable,
  input wire logic external_bus_request,
  input wire logic refresh_due,
  input wire logic refresh_req,
  input wire logic dtc_req,
  input wire logic dmac_req,
  input wire logic dmac_hold,
  input wire logic cpu_req,
  input wire logic acc_valid,
  input wire bia_pkg::bia_access_t acc,
  input wire logic acc_done,
  output logic acc_ready,
  output bia_pkg::bia_grant_t bus_grant,
  output logic [3:0] chip_select_n,
  output logic dram_active,
  output logic refresh_request_out,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_pc,
  output logic fetch_go,
  output logic [31:0] fetch_addr,
  output logic [1:0] fetch_words
);
  import bia_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } bia_state_t;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] conflict_idle(input bia_idle_cfg_t c, input bia_space_t s);
    if (s == SP_DRAM) begin
      conflict_idle = {1'b0, c.dram_read_turnaround_idle};
    end else begin
      conflict_idle = c.read_turnaround_idle_fields[{s[1:0], 1'b0} +: `BIA_IW_W];
    end
  endfunction

  function automatic logic [3:0] cs_decode(input bia_space_t s);
    cs_decode = `BIA_CS_OFF;
    if (s != SP_DRAM) begin
      cs_decode[s[1:0]] = 1'b0;
    end
  endfunction

  // ----------------------------------------------------------------
  // external request pin
  // ----------------------------------------------------------------
  logic ext_req_sync;

  bia_sync #(
    .W(1)
  ) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in(external_bus_request),
    .sync_out(ext_req_sync)
  );

  // ----------------------------------------------------------------
  // idle insertion
  // ----------------------------------------------------------------
  bia_state_t state;
  bia_state_t next_state;
  logic [1:0] idle_cnt;
  logic [1:0] next_idle_cnt;
  bia_space_t last_space;
  bia_space_t next_last_space;
  logic last_read;
  logic next_last_read;
  logic last_valid;
  logic next_last_valid;
  logic [3:0] next_chip_select_n;
  logic next_dram_active;
  logic conflict;
  logic same_cs;
  logic [1:0] ci;
  logic [1:0] ci_rem;
  logic [1:0] cw;
  logic [1:0] need;

  always_comb begin
    conflict = last_valid && last_read && (acc.write || acc.space != last_space);
    ci = conflict ? conflict_idle(idle_cfg, last_space) : 2'h0;
    ci_rem = (ci > idle_cnt) ? ci - idle_cnt : 2'h0;
    same_cs = last_valid && acc.space == last_space && acc.space != SP_DRAM;
    cw = 2'h0;
    if (same_cs && idle_cnt == 2'h0 && idle_cfg.same_space_idle_fields[acc.space[1:0]]) begin
      cw = `BIA_CW_IDLE;
    end
    need = (ci_rem > cw) ? ci_rem : cw;
  end

  // an access may start only on an internally owned bus with no idle owed
  assign acc_ready = state == ST_IDLE && acc_valid && need == 2'h0 && bus_grant != GR_EXT;

  always_comb begin
    next_state = state;
    next_idle_cnt = idle_cnt;
    next_last_space = last_space;
    next_last_read = last_read;
    next_last_valid = last_valid;
    next_chip_select_n = chip_select_n;
    next_dram_active = dram_active;
    unique case (state)
      ST_IDLE: begin
        if (acc_ready) begin
          next_state = ST_BUSY;
          next_last_space = acc.space;
          next_last_read = !acc.write;
          next_last_valid = 1'b1;
          next_chip_select_n = cs_decode(acc.space);
          next_dram_active = acc.space == SP_DRAM;
        end else if (idle_cnt != `BIA_IDLE_SAT) begin
          next_idle_cnt = idle_cnt + 2'h1;
        end
      end
      ST_BUSY: begin
        if (acc_done) begin
          next_state = ST_IDLE;
          next_idle_cnt = `BIA_IDLE_RST;
          next_chip_select_n = `BIA_CS_OFF;
          next_dram_active = 1'b0;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_chip_select_n = `BIA_CS_OFF;
        next_dram_active = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      idle_cnt <= `BIA_IDLE_SAT;
      last_space <= SP_CS0;
      last_read <= 1'b0;
      last_valid <= 1'b0;
      chip_select_n <= `BIA_CS_OFF;
      dram_active <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      idle_cnt <= next_idle_cnt;
      last_space <= next_last_space;
      last_read <= next_last_read;
      last_valid <= next_last_valid;
      chip_select_n <= next_chip_select_n;
      dram_active <= next_dram_active;
    end
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  bia_req_t req;
  logic lock;

  assign req = '{ext: ext_req_sync, rfsh: refresh_req, data_transfer_ctrl: dtc_req, dmac: dmac_req,
                 cpu: cpu_req};
  assign lock = state == ST_BUSY || acc_ready;

  bia_arb u_arb (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .req(req),
    .lock(lock),
    .dmac_hold(dmac_hold),
    .grant(bus_grant)
  );

  // ----------------------------------------------------------------
  // refresh request while released
  // ----------------------------------------------------------------
  logic refresh_pending;
  logic next_refresh_pending;
  logic next_refresh_request_out;

  always_comb begin
    next_refresh_pending = refresh_pending;
    if (bus_grant == GR_RFSH) begin
      next_refresh_pending = 1'b0;
    end
    if (refresh_due) begin
      next_refresh_pending = 1'b1;
    end
    next_refresh_request_out = refresh_out_enable && next_refresh_pending
                               && bus_grant == GR_EXT;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      refresh_pending <= 1'b0;
      refresh_request_out <= 1'b0;
    end else if (clk_en) begin
      refresh_pending <= next_refresh_pending;
      refresh_request_out <= next_refresh_request_out;
    end
  end

  // ----------------------------------------------------------------
  // instruction fetch width
  // ----------------------------------------------------------------
  logic next_fetch_go;
  logic [31:0] next_fetch_addr;

  always_comb begin
    next_fetch_go = fetch_valid;
    next_fetch_addr = fetch_addr;
    if (fetch_valid) begin
      next_fetch_addr = {fetch_pc[31:2], `BIA_FETCH_ALIGN};
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fetch_go <= 1'b0;
      fetch_addr <= 32'h0;
      fetch_words <= `BIA_FETCH_WORDS;
    end else if (clk_en) begin
      fetch_go <= next_fetch_go;
      fetch_addr <= next_fetch_addr;
      fetch_words <= `BIA_FETCH_WORDS;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst || !clk_en);

  sequence s_start;
    acc_ready;
  endsequence

  sequence s_cycle_end;
    state == ST_BUSY && acc_done;
  endsequence

  property p_conflict_gap;
    s_cycle_end ##1 (acc_valid && last_read && (acc.write || acc.space != last_space)
      && conflict_idle(idle_cfg, last_space) != 2'h0) |-> !acc_ready;
  endproperty
  a_conflict_gap: assert property (p_conflict_gap) else $error("read turnaround idle short");

  property p_same_space_idle;
    s_cycle_end ##1 (acc_valid && acc.space == last_space && acc.space != SP_DRAM
      && idle_cfg.same_space_idle_fields[acc.space[1:0]]) |-> !acc_ready;
  endproperty
  a_same_space_idle: assert property (p_same_space_idle) else $error("same space idle missed");

  property p_dram_bound;
    last_valid && last_space == SP_DRAM |-> need <= 2'h1;
  endproperty
  a_dram_bound: assert property (p_dram_bound) else $error("dram idle above one");

  property p_cs_negated;
    s_cycle_end |=> chip_select_n == `BIA_CS_OFF && !dram_active;
  endproperty
  a_cs_negated: assert property (p_cs_negated) else $error("chip select not negated");

  property p_cs_drive;
    s_start |=> chip_select_n == cs_decode($past(acc.space)) && state == ST_BUSY;
  endproperty
  a_cs_drive: assert property (p_cs_drive) else $error("chip select wrong");

  property p_ext_first;
    ext_req_sync && !lock |=> bus_grant == GR_EXT;
  endproperty
  a_ext_first: assert property (p_ext_first) else $error("external request not first");

  property p_refresh_second;
    !ext_req_sync && refresh_req && !lock |=> bus_grant == GR_RFSH;
  endproperty
  a_refresh_second: assert property (p_refresh_second) else $error("refresh not second");

  property p_dmac_keeps;
    bus_grant == GR_DMAC && dmac_hold && dmac_req && !ext_req_sync && !refresh_req
      |=> bus_grant == GR_DMAC;
  endproperty
  a_dmac_keeps: assert property (p_dmac_keeps) else $error("dma lost bus to dtc");

  property p_no_release_in_cycle;
    state == ST_BUSY && !acc_done |=> $stable(bus_grant);
  endproperty
  a_no_release_in_cycle: assert property (p_no_release_in_cycle) else $error("bus moved in cycle");

  property p_refresh_out;
    refresh_out_enable && refresh_due && bus_grant == GR_EXT |=> refresh_request_out;
  endproperty
  a_refresh_out: assert property (p_refresh_out) else $error("refresh request not raised");

  property p_ready_needs_bus;
    acc_ready |-> bus_grant != GR_EXT && state == ST_IDLE;
  endproperty
  a_ready_needs_bus: assert property (p_ready_needs_bus) else $error("start on released bus");

  property p_fetch_pair;
    fetch_valid |=> fetch_go && fetch_addr[1:0] == 2'h0
      && fetch_addr[31:2] == $past(fetch_pc[31:2]) && fetch_words == 2'h2;
  endproperty
  a_fetch_pair: assert property (p_fetch_pair) else $error("fetch not a word pair");

endmodule // bia_top
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bia_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  bia_idle_cfg_t idle_cfg = '0;
  logic rfo_en = 1'b0, ext_want = 1'b0, ext_req, refresh_due = 1'b0, refresh_req = 1'b0;
  logic dtc_req = 1'b0, dmac_req = 1'b0, dmac_hold = 1'b0, cpu_req = 1'b1;
  logic clk_en = 1'b1;
  logic acc_valid = 1'b0, acc_done = 1'b0, acc_ready, dram_active, rfo, fetch_valid = 1'b0;
  logic fetch_go, pfv, nfv;
  bia_access_t acc = '0;
  bia_grant_t bus_grant, g;
  logic [3:0] chip_select_n;
  logic [1:0] fetch_words;
  logic [31:0] fetch_pc = '0, fetch_addr, pfa, nfa, rnd = 32'h2FF1;
  // no earlier access: a space code that never matches a real one
  logic [2:0] last_sp = 3'h7;
  logic last_wr = 1'b1;
  int fail_count = 0;
  int n_tests = 0;

  always #5 mclk = ~mclk;

  bia_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .idle_cfg(idle_cfg),
    .refresh_out_enable(rfo_en), .external_bus_request(ext_req), .refresh_due(refresh_due),
    .refresh_req(refresh_req), .dtc_req(dtc_req), .dmac_req(dmac_req), .dmac_hold(dmac_hold),
    .cpu_req(cpu_req), .acc_valid(acc_valid), .acc(acc), .acc_done(acc_done),
    .acc_ready(acc_ready), .bus_grant(bus_grant), .chip_select_n(chip_select_n),
    .dram_active(dram_active), .refresh_request_out(rfo), .fetch_valid(fetch_valid),
    .fetch_pc(fetch_pc), .fetch_go(fetch_go), .fetch_addr(fetch_addr),
    .fetch_words(fetch_words));

  bia_ext_master ext_u (.mclk(mclk), .sys_rst(sys_rst), .want(ext_want),
    .refresh_request_out(rfo), .external_bus_request(ext_req));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic test_done;
    if (fail_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  function automatic void next_rnd();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
  endfunction

  function automatic int exp_wait(input logic [2:0] sp, input logic wr, input int gap);
    int need;
    need = 0;
    if (!last_wr && (wr || sp != last_sp)) begin
      need = (last_sp == 3'h4) ? int'(idle_cfg.dram_read_turnaround_idle)
                               : int'(idle_cfg.read_turnaround_idle_fields[2*last_sp +: 2]);
    end
    if (sp == last_sp && sp != 3'h4 && idle_cfg.same_space_idle_fields[sp[1:0]] && need < 1) begin
      need = 1;
    end
    return (need > gap) ? need - gap : 0;
  endfunction

  function automatic bia_grant_t exp_grant(input logic [4:0] r, input bia_grant_t cur);
    if (r[4]) return GR_EXT;
    if (r[3]) return GR_RFSH;
    if (r[2] && !(cur == GR_DMAC && r[1] && r[0])) return GR_DTC;
    if (r[1]) return GR_DMAC;
    return GR_CPU;
  endfunction

  // one bus cycle of len memory accesses, raised gap idle cycles after the last one
  task automatic do_acc(input logic [2:0] sp, input logic wr, input int len, input int gap,
                        input logic poke);
    int waits;
    int exp_w;
    bia_grant_t g0;
    waits = 0;
    repeat (gap) @(posedge mclk);
    acc_valid <= 1'b1;
    acc <= '{space: bia_space_t'(sp), write: wr};
    @(negedge mclk);
    exp_w = exp_wait(sp, wr, gap);
    g0 = bus_grant;
    while (acc_ready !== 1'b1 && waits < 8) begin
      check(chip_select_n, 4'hF);
      waits++;
      @(negedge mclk);
    end
    check(waits, exp_w);
    if (waits >= 8) test_done();
    @(posedge mclk);
    acc_valid <= 1'b0;
    if (len > 1) dtc_req <= poke;
    repeat (len - 1) @(posedge mclk);
    acc_done <= 1'b1;
    dtc_req <= 1'b0;
    @(negedge mclk);
    check(chip_select_n, (sp == 3'h4) ? 4'hF : 4'(~(4'h1 << sp[1:0])));
    check(dram_active, sp == 3'h4);
    check(bus_grant, g0);
    @(posedge mclk);
    acc_done <= 1'b0;
    last_sp = sp;
    last_wr = wr;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk);
    check(bus_grant, GR_CPU);
    check(chip_select_n, 4'hF);
    check({dram_active, rfo}, 2'h0);
    pfv = 1'b0;
    pfa = 32'h0;
    for (int i = 0; i < 20; i++) begin
      @(posedge mclk);
      next_rnd();
      nfv = rnd[0] | (i < 4);
      nfa = {rnd[31:2], 2'h0};
      fetch_valid <= nfv;
      fetch_pc <= rnd;
      @(negedge mclk);
      check(fetch_go, pfv);
      check(fetch_addr, pfa);
      check(fetch_words, 2'h2);
      pfv = nfv;
      if (nfv) pfa = nfa;
    end
    @(posedge mclk);
    fetch_valid <= 1'b0;
    clk_en <= 1'b0;
    dtc_req <= 1'b1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    check(bus_grant, GR_CPU);
    @(posedge mclk);
    clk_en <= 1'b1;
    repeat (2) @(negedge mclk);
    check(bus_grant, GR_DTC);
    @(posedge mclk);
    dtc_req <= 1'b0;
    repeat (2) @(negedge mclk);
    g = bus_grant;
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk);
      next_rnd();
      refresh_req <= rnd[4];
      dtc_req <= rnd[3];
      dmac_req <= rnd[2];
      dmac_hold <= rnd[2] & rnd[1];
      cpu_req <= rnd[0];
      @(negedge mclk);
      @(negedge mclk);
      check(bus_grant, exp_grant({1'b0, rnd[4:2], rnd[2] & rnd[1]}, g));
      g = bus_grant;
    end
    @(posedge mclk);
    {refresh_req, dtc_req, dmac_req, dmac_hold} <= 4'h0;
    cpu_req <= 1'b1;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 120; i++) begin
      next_rnd();
      if (rnd[1:0] == 2'h0) idle_cfg <= rnd[28:16];
      do_acc(3'(rnd[6:4] % 5), rnd[7], 1 + int'(rnd[9:8]),
             (rnd[11:10] == 2'h3) ? int'(rnd[13:12]) : 0, rnd[14]);
    end
    @(posedge mclk);
    refresh_req <= 1'b1;
    ext_want <= 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    check(bus_grant, GR_EXT);
    @(posedge mclk);
    refresh_due <= 1'b1;
    acc_valid <= 1'b1;
    @(negedge mclk);
    check(acc_ready, 1'b0);
    @(posedge mclk);
    refresh_due <= 1'b0;
    acc_valid <= 1'b0;
    @(negedge mclk);
    check(rfo, 1'b0);
    @(posedge mclk);
    rfo_en <= 1'b1;
    @(negedge mclk);
    @(negedge mclk);
    check(rfo, 1'b1);
    for (int k = 0; k < 20 && bus_grant !== GR_RFSH; k++) @(negedge mclk);
    check(bus_grant, GR_RFSH);
    if (bus_grant !== GR_RFSH) test_done();
    @(negedge mclk);
    @(negedge mclk);
    check(rfo, 1'b0);
    test_done();
  end
endmodule // testbench
`default_nettype wire
